// ### hdl/wdt_top.sv
// Watchdog timer with timed-sequence control, APB register slave
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top (
    // Processor clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // Watchdog oscillator
    input  wire logic        osc_clk,
    // Straps and events
    input  wire logic        always_on_fuse,
    input  wire logic        power_on_rst,
    input  wire logic        dog_restart_instruction,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    // Reset and interrupt outputs
    output logic             wdt_reset_pulse,
    output logic             reset_delay_start,
    output logic             irq
);
    logic       en_reg;
    logic       ce_reg;
    logic [2:0] ce_cnt_reg;
    logic [2:0] presc_reg;
    logic       fuse_reg;
    logic       flag_reg;
    logic       irq_stat_reg;
    logic       irq_en_reg;
    logic       restart_tgl_reg;
    logic       exp_s1_reg, exp_s2_reg, exp_s3_reg;
    logic       osc_rst_b;
    logic       expire_tgl;
    logic       expire_evt;
    logic       eff_en;
    logic       wr, rd_ok;
    logic       wr_ctrl;
    logic       ce_wr, en_wr;
    logic       restart_cmd;
    wdt_pkg::wdt_rst_state_t state_reg;

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ref_a);
        addr_hit = (a == ref_a);
    endfunction : addr_hit

    assign pready  = 1'b1;
    assign wr      = psel && penable && pwrite;
    assign wr_ctrl = wr && addr_hit(paddr, `WDT_CTRL_ADDR);
    assign ce_wr   = pwdata[`WDT_CE_BIT];
    assign en_wr   = pwdata[`WDT_EN_BIT];
    assign eff_en  = en_reg || fuse_reg; // see [R12]
    assign rd_ok   = addr_hit(paddr, `WDT_CTRL_ADDR) || addr_hit(paddr, `WDT_RSTAT_ADDR)
                  || addr_hit(paddr, `WDT_CMD_ADDR) || addr_hit(paddr, `WDT_IRQ_STAT_ADDR)
                  || addr_hit(paddr, `WDT_IRQ_EN_ADDR) || addr_hit(paddr, `WDT_IRQ_CLR_ADDR);
    assign pslverr = psel && penable && !rd_ok;

    // Fuse is a strap, caught by a clocked process during reset
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fuse_reg <= always_on_fuse;
        end
    end

    // Change window: opens on a write of both change-enable and enable, four cycles long
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (wr_ctrl && ce_wr && en_wr) begin
            ce_reg     <= 1'b1; // see [R8] see [R11] see [R13]
            ce_cnt_reg <= `WDT_CE_CYCLES;
        end else if (wr_ctrl && ce_reg) begin
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (ce_reg) begin
            ce_cnt_reg <= ce_cnt_reg - 3'h1;
            if (ce_cnt_reg == 3'h1) begin
                ce_reg <= 1'b0; // see [R6]
            end
        end
    end

    // Enable and prescale, protected by the change window
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            en_reg    <= 1'b0; // see [R10]
            presc_reg <= `WDT_PRESC_RESET;
        end else if (wr_ctrl && !ce_wr && ce_reg) begin
            presc_reg <= pwdata[2:0]; // see [R9] see [R11]
            if (!fuse_reg) begin
                en_reg <= en_wr; // see [R7] see [R13]
            end
        end else if (wr_ctrl && en_wr) begin
            en_reg <= 1'b1; // see [R7] see [R10] see [R16]
        end
    end

    // Oscillator domain reset follows the chip reset only; the counter already wraps to zero at a
    // time-out, and resetting the expiry toggle there would send a second, false time-out back
    logic orst_s1_reg, orst_s2_reg;
    always_ff @(posedge osc_clk) begin
        orst_s1_reg <= rst_b;
        orst_s2_reg <= orst_s1_reg;
    end
    assign osc_rst_b = orst_s2_reg; // see [R3]

    assign restart_cmd = wr && addr_hit(paddr, `WDT_CMD_ADDR) && pwdata[`WDT_CMD_RESTART];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            restart_tgl_reg <= 1'b0;
        end else if (dog_restart_instruction || restart_cmd) begin
            restart_tgl_reg <= ~restart_tgl_reg; // see [R2]
        end
    end

    wdt_osc_counter u_counter (
        .osc_clk      (osc_clk),
        .osc_rst_b    (osc_rst_b),
        .enable_lvl   (eff_en),
        .prescale_lvl (presc_reg),
        .restart_tgl  (restart_tgl_reg),
        .expire_tgl   (expire_tgl)
    );

    // Time-out toggle back into the processor domain
    always_ff @(posedge core_clk) begin
        exp_s1_reg <= expire_tgl;
        exp_s2_reg <= exp_s1_reg;
        exp_s3_reg <= exp_s2_reg; // see [R17]
    end
    assign expire_evt = (exp_s2_reg != exp_s3_reg) && rst_b;

    // Reset pulse sequencer: one-cycle pulse, then start of the delay at its fall
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg         <= wdt_pkg::ST_IDLE;
            wdt_reset_pulse   <= 1'b0;
            reset_delay_start <= 1'b0;
        end else begin
            case (state_reg)
                wdt_pkg::ST_IDLE: begin
                    reset_delay_start <= 1'b0;
                    if (expire_evt && eff_en) begin
                        state_reg       <= wdt_pkg::ST_PULSE;
                        wdt_reset_pulse <= 1'b1; // see [R4] see [R14]
                    end
                end
                wdt_pkg::ST_PULSE: begin
                    state_reg         <= wdt_pkg::ST_HOLD;
                    wdt_reset_pulse   <= 1'b0;
                    reset_delay_start <= 1'b1; // see [R14]
                end
                default: begin
                    state_reg         <= wdt_pkg::ST_IDLE;
                    reset_delay_start <= 1'b0;
                end
            endcase
        end
    end

    // Reset flag survives chip reset; only power-on reset or software clears it
    always_ff @(posedge core_clk) begin
        if (power_on_rst) begin
            flag_reg <= 1'b0;
        end else if (wdt_reset_pulse) begin
            flag_reg <= 1'b1; // see [R15]
        end else if (wr && addr_hit(paddr, `WDT_RSTAT_ADDR) && !pwdata[`WDT_FLAG_BIT]) begin
            flag_reg <= 1'b0; // see [R15]
        end
    end

    // Interrupt: set wins over clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_stat_reg <= 1'b0;
            irq_en_reg   <= 1'b0;
        end else begin
            if (wdt_reset_pulse) begin
                irq_stat_reg <= 1'b1;
            end else if (wr && addr_hit(paddr, `WDT_IRQ_CLR_ADDR) && pwdata[0]) begin
                irq_stat_reg <= 1'b0;
            end
            if (wr && addr_hit(paddr, `WDT_IRQ_EN_ADDR)) begin
                irq_en_reg <= pwdata[0];
            end
        end
    end
    assign irq = irq_stat_reg && irq_en_reg;

    // Read data registered on the setup cycle so it is stable in the access phase
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (addr_hit(paddr, `WDT_CTRL_ADDR)) begin
                prdata <= {24'h0, 3'h0, ce_reg, eff_en, presc_reg}; // see [R5] see [R12]
            end else if (addr_hit(paddr, `WDT_RSTAT_ADDR)) begin
                prdata <= 32'(flag_reg) << `WDT_FLAG_BIT;
            end else if (addr_hit(paddr, `WDT_IRQ_STAT_ADDR)) begin
                prdata <= {31'h0, irq_stat_reg};
            end else if (addr_hit(paddr, `WDT_IRQ_EN_ADDR)) begin
                prdata <= {31'h0, irq_en_reg};
            end else begin
                prdata <= 32'h0;
            end
        end
    end
endmodule : wdt_top

// ### hdl/wdt_consts.svh
// Constants for the watchdog timer block
// Function
// [R1] Watchdog counter runs on its own oscillator clock, independent of the processor clock.
// [R2] The restart instruction clears the watchdog counter so the period starts again.
// [R3] The counter also clears when the watchdog is disabled and on any chip reset.
// [R4] Period elapsing without restart resets the device, which starts from its reset vector.
// [R5] Control bits 7 to 5 are reserved and always read zero.
// [R6] Change-enable is bit 4; hardware clears it four cycles after it is written.
// [R7] Enable is bit 3; one enables, zero only takes effect with change-enable set.
// [R8] Software disables by writing change-enable and enable, then enable zero within four cycles.
// [R9] Prescale bits 2..0 select 16384 oscillator cycles, doubling per code up to 2097152.
// [R10] Fuse unprogrammed: starts disabled; enabling by writing one needs no timed sequence.
// [R11] Fuse unprogrammed: timeout or disable change needs the two-write timed sequence.
// [R12] Fuse programmed: watchdog always enabled and the enable bit always reads one.
// [R13] Fuse programmed: timed sequence changes prescale only; written enable value ignored.
// [R14] A time-out gives a one-cycle internal reset pulse; the delay starts at its fall.
// [R15] A watchdog reset sets the reset flag, cleared by power-on reset or writing zero.
// [R16] Protected writes outside an open change window leave protected fields unchanged.
// [R17] Restart and control cross into the oscillator domain; time-out crosses back safely.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

`define WDT_CTRL_ADDR      12'h000
`define WDT_RSTAT_ADDR     12'h004
`define WDT_CMD_ADDR       12'h008
`define WDT_IRQ_STAT_ADDR  12'h00C
`define WDT_IRQ_EN_ADDR    12'h010
`define WDT_IRQ_CLR_ADDR   12'h014
`define WDT_CE_BIT         4
`define WDT_EN_BIT         3
`define WDT_FLAG_BIT       3
`define WDT_CMD_RESTART    0
`define WDT_CE_CYCLES      3'h4
`define WDT_PRESC_RESET    3'h0
`define WDT_BASE_LOG2      14
`define WDT_CNT_W          22
`define WDT_OSC_HZ         1000000

`endif

// ### hdl/wdt_pkg.sv
// Types for the watchdog timer block
package wdt_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PULSE = 3'b010,
        ST_HOLD  = 3'b100
    } wdt_rst_state_t;
endpackage : wdt_pkg

// ### hdl/wdt_osc_counter.sv
// Watchdog counter running on its own oscillator clock
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_osc_counter (
    // Oscillator domain
    input  wire logic       osc_clk,
    input  wire logic       osc_rst_b,
    // Levels and toggles from the processor domain
    input  wire logic       enable_lvl,
    input  wire logic [2:0] prescale_lvl,
    input  wire logic       restart_tgl,
    // Time-out event, as a toggle
    output logic            expire_tgl
);
    logic       en_s1_reg, en_s2_reg;
    logic [2:0] pr_s1_reg, pr_s2_reg, pr_s3_reg, pr_use_reg;
    logic       rs_s1_reg, rs_s2_reg, rs_s3_reg;
    logic [`WDT_CNT_W-1:0] cnt_reg;
    logic [`WDT_CNT_W-1:0] limit;

    // Prescale is a bus: it is taken only once two samples agree, so skewed bits never reach the limit
    always_ff @(posedge osc_clk) begin
        en_s1_reg <= enable_lvl;
        en_s2_reg <= en_s1_reg;
        pr_s1_reg <= prescale_lvl;
        pr_s2_reg <= pr_s1_reg;
        pr_s3_reg <= pr_s2_reg;
        rs_s1_reg <= restart_tgl;
        rs_s2_reg <= rs_s1_reg;
        rs_s3_reg <= rs_s2_reg; // see [R17]
    end

    always_ff @(posedge osc_clk) begin
        if (!osc_rst_b) begin
            pr_use_reg <= `WDT_PRESC_RESET;
        end else if (pr_s2_reg == pr_s3_reg) begin
            pr_use_reg <= pr_s2_reg; // see [R17]
        end
    end

    assign limit = `WDT_CNT_W'(1) << (`WDT_BASE_LOG2 + 32'(pr_use_reg)); // see [R9]

    always_ff @(posedge osc_clk) begin
        if (!osc_rst_b) begin
            cnt_reg    <= '0; // see [R3]
            expire_tgl <= 1'b0;
        end else if (!en_s2_reg || (rs_s2_reg != rs_s3_reg)) begin
            cnt_reg <= '0; // see [R2] see [R3]
        end else if (cnt_reg >= limit - `WDT_CNT_W'(1)) begin
            cnt_reg    <= '0;
            expire_tgl <= ~expire_tgl; // see [R4]
        end else begin
            cnt_reg <= cnt_reg + `WDT_CNT_W'(1); // see [R1]
        end
    end
endmodule : wdt_osc_counter

// ### verif/wdt_sva.sv
// Property checker for the watchdog top ports
`timescale 1ns/1ps
module wdt_sva (
    // Clock, reset, strap
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        always_on_fuse,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // Reset outputs
    input wire logic        wdt_reset_pulse,
    input wire logic        reset_delay_start
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic acc_rd = psel && penable && !pwrite;
    wire logic ctl_rd = acc_rd && paddr == 12'h000;
    wire logic bad_ad = paddr > 12'h014 || paddr[1:0] != 2'h0;
    pulse_short_a: assert property (wdt_reset_pulse |=> !wdt_reset_pulse) else $error("long pulse");
    delay_follow_a: assert property (wdt_reset_pulse |=> reset_delay_start) else $error("no delay");
    delay_cause_a: assert property (reset_delay_start |-> $past(wdt_reset_pulse)) else $error("stray");
    reserved_zero_a: assert property (ctl_rd |-> prdata[7:5] == 3'h0) else $error("reserved set");
    fuse_enable_a: assert property (ctl_rd && always_on_fuse |-> prdata[3]) else $error("enable low");
    unmapped_err_a: assert property (psel && penable && bad_ad |-> pslverr) else $error("no error");
    mapped_ok_a: assert property (psel && penable && !bad_ad |-> !pslverr) else $error("false error");
    err_data_a: assert property (acc_rd && pslverr |-> prdata == 32'h0) else $error("refused data");
endmodule : wdt_sva
bind wdt_top wdt_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .always_on_fuse(always_on_fuse),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr), .prdata(prdata),
    .wdt_reset_pulse(wdt_reset_pulse), .reset_delay_start(reset_delay_start));

// ### verif/cpu_model.sv
// Processor core model: register bus master and restart source
`timescale 1ns/1ps
module cpu_model (
    // Clock and bus answer
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    // Bus request and restart
    output logic             psel    = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite  = 1'b0,
    output logic [11:0]      paddr   = 12'h000,
    output logic [31:0]      pwdata  = 32'h0,
    output logic             restart = 1'b0
);
    int stalls = 0;
    // Idle cycle before each setup: no signal is assigned twice in one step
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n == 64) stalls++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : xfer
    // Second write lands three cycles after the first, inside the window
    task automatic unlock(input logic [7:0] v);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, 12'h000, 32'h18, r, e);
        xfer(1'b1, 12'h000, {24'h0, v}, r, e);
    endtask : unlock
    task automatic kick();
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
    endtask : kick
endmodule : cpu_model

// ### verif/watchdog_timer_timed_control_bench.sv
// Self-checking bench for the watchdog timer block
`timescale 1ns/1ps
module watchdog_timer_timed_control_bench;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
    localparam real OSC_HALF = 3.1;
    localparam int  TMO      = int'(16384 * 2 * OSC_HALF / 100);
    logic             core_clk = 1'b0;
    logic             osc_clk  = 1'b0;
    logic             rst_b    = 1'b0;
    logic             fuse     = 1'b0;
    logic             por      = 1'b1;
    logic [31:0]      r;
    logic             e;
    wire logic        psel, penable, pwrite, pready, pslverr, restart, pulse, irq;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    int               n_fail      = 0;
    int               check_count = 0;
    int               t;
    row_t rows [7] = '{'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0}, '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h018, 32'h0, 32'h0, 1'b1}, '{1'b0, 12'h004, 32'h0, 32'h0, 1'b0},
        '{1'b1, 12'h000, 32'hE8, 32'h0, 1'b0}, '{1'b1, 12'h000, 32'h3, 32'h0, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'h8, 1'b0}};
    always #50 core_clk = ~core_clk;
    // Sped-up oscillator keeps the shortest time-out near a thousand cycles
    always #OSC_HALF osc_clk = ~osc_clk;
    cpu_model u_cpu (.clk(core_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .restart(restart));
    wdt_top u_dut (.core_clk(core_clk), .rst_b(rst_b), .osc_clk(osc_clk), .always_on_fuse(fuse),
        .power_on_rst(por), .dog_restart_instruction(restart), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .wdt_reset_pulse(pulse), .reset_delay_start(), .irq(irq));
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask : chk1
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
        u_cpu.xfer(w, a, d, r, e);
        if (!w) chk32(r, x);
    endtask : acc
    task automatic report_and_stop();
        n_fail += u_cpu.stalls;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    task automatic wait_pulse();
        t = 0;
        // Sampled mid-cycle: the pulse stands for one cycle only
        while (pulse !== 1'b1 && t < 3000) begin
            @(negedge core_clk);
            t++;
        end
        if (t == 3000) n_fail++;
        if (t == 3000) report_and_stop();
    endtask : wait_pulse
    task automatic do_reset(input logic f);
        rst_b <= 1'b0;
        fuse  <= f;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask : do_reset
    initial begin
        // Power-on reset stands with the first chip reset so the reset flag starts known
        do_reset(1'b0);
        por <= 1'b0;
        foreach (rows[i]) begin
            u_cpu.xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
            chk1(e, rows[i].e);
            if (!rows[i].w) chk32(r, rows[i].x);
        end
        acc(1'b1, 12'h000, 32'h18, 32'h0);
        acc(1'b0, 12'h000, 32'h0, 32'h18);
        repeat (4) @(posedge core_clk);
        acc(1'b0, 12'h000, 32'h0, 32'h8);
        acc(1'b1, 12'h000, 32'h0, 32'h0);
        acc(1'b0, 12'h000, 32'h0, 32'h8);
        for (int p = 7; p >= 0; p--) begin
            u_cpu.unlock(8'h08 | 8'(p));
            acc(1'b0, 12'h000, 32'h0, 32'h8 | 32'(p));
        end
        u_cpu.unlock(8'h00);
        acc(1'b0, 12'h000, 32'h0, 32'h0);
        acc(1'b1, 12'h000, 32'h8, 32'h0);
        repeat (4) begin
            repeat (600) @(posedge core_clk);
            @(negedge core_clk);
            chk1(pulse, 1'b0);
            u_cpu.kick();
        end
        // Restart by command write as well; the flag shows that no time-out slipped in between
        repeat (600) @(posedge core_clk);
        acc(1'b0, 12'h004, 32'h0, 32'h0);
        acc(1'b1, 12'h008, 32'h1, 32'h0);
        wait_pulse();
        chk1(t >= TMO - 3 && t <= TMO + 12, 1'b1);
        @(negedge core_clk);
        chk1(irq, 1'b0);
        acc(1'b0, 12'h004, 32'h0, 32'h8);
        acc(1'b0, 12'h00C, 32'h0, 32'h1);
        acc(1'b1, 12'h010, 32'h1, 32'h0);
        @(negedge core_clk);
        chk1(irq, 1'b1);
        acc(1'b1, 12'h014, 32'h1, 32'h0);
        @(negedge core_clk);
        chk1(irq, 1'b0);
        acc(1'b1, 12'h004, 32'h0, 32'h0);
        acc(1'b0, 12'h004, 32'h0, 32'h0);
        acc(1'b1, 12'h000, 32'h8, 32'h0);
        u_cpu.kick();
        wait_pulse();
        repeat (4) @(posedge core_clk);
        por <= 1'b1;
        repeat (3) @(posedge core_clk);
        por <= 1'b0;
        acc(1'b0, 12'h004, 32'h0, 32'h0);
        do_reset(1'b1);
        acc(1'b0, 12'h000, 32'h0, 32'h8);
        u_cpu.unlock(8'h01);
        acc(1'b0, 12'h000, 32'h0, 32'h9);
        acc(1'b1, 12'h000, 32'h0, 32'h0);
        acc(1'b0, 12'h000, 32'h0, 32'h9);
        report_and_stop();
    end
endmodule : watchdog_timer_timed_control_bench
